// ### verilog/hub_power_defines.svh
// ==========================================================================
// Hub port power and strap control: constants
// ==========================================================================
// Clock rates, counts and reset values shared by the power control logic.
// Assumes it is included by its bare name from files under verilog/ and verif/.
// How it works
// - Ganged strap high: all enables switch together
// - Ganged: any overcurrent powers off every port
// - Ganged strap low: ports act independently
// - Clock select low: internal PLL clocks core
// - Clock select high: external clock, PLL/oscillator off
// - PLL makes 48 MHz, keeps 12 MHz synchronised
// - EEPROM off: default IDs, clock pin off, gang
// - EEPROM on: shared pins become EEPROM clock/data
// - Slew rate follows attached device speed
// - Bus power strap selects bus/self powered
// - EEPROM outputs released when not in use
// - Overcurrent inputs filtered against short spikes
// - Power enables active low, push-pull driven
// - Overcurrent inputs active low, any in ganged
// - Reset at power-up initialises all logic
`ifndef HUB_POWER_DEFINES_SVH
`define HUB_POWER_DEFINES_SVH

`define NUM_PORTS         4
`define OC_FILTER_CYCLES  8
`define STRAP_SYNC_CYCLES 2
`define PLL_REF_MHZ       6
`define PLL_OUT_MHZ       48
`define USB_BIT_MHZ       12
`define PORTS_OFF_N       4'hF
`define OC_IDLE_N         4'hF
`define STRAP_RESET       4'h0

`endif

// ### verilog/hub_power_pkg.sv
// ==========================================================================
// Hub port power and strap control: types
// ==========================================================================
// Types shared by the control logic and its bench.
// Assumes the defines header carries every number.
package hub_power_pkg;

    // Straps captured once after reset release
    typedef struct packed {
        logic bus_powered;
        logic ext_clock;
        logic eeprom_off;
        logic ganged;
    } straps_t;

    // Capture sequencer
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_RUN    = 2'b01
    } cap_state_t;

endpackage : hub_power_pkg

// ### verilog/hub_port_power_strap_control.sv
// ==========================================================================
// Hub port power and strap control
// ==========================================================================
// Straps, clock source control, EEPROM pin sharing, overcurrent filtering
// and port power enables for a four port hub.
// Assumes hub core logic on clk supplies power requests, speed and EEPROM
// engine drive; strap and overcurrent pins arrive asynchronously.
`timescale 1ns/1ps
`include "hub_power_defines.svh"

module hub_port_power_strap_control #(
    parameter int OC_CYCLES = `OC_FILTER_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     bus_power_strap,
    input  wire logic                     clock_source_select,
    input  wire logic                     eeprom_disable_strap,
    input  wire logic [`NUM_PORTS-1:0]    port_overcurrent_n,
    input  wire logic [`NUM_PORTS-1:0]    port_power_request,
    input  wire logic [`NUM_PORTS-1:0]    port_low_speed,
    input  wire logic                     ee_active,
    input  wire logic                     ee_clock_drive,
    input  wire logic                     ee_data_drive,
    input  wire logic                     ee_data_oe_req,
    input  wire logic                     eeprom_serial_data_in,
    output logic                          eeprom_serial_clock_out,
    output logic                          eeprom_serial_clock_oe,
    output logic                          eeprom_serial_data_out,
    output logic                          eeprom_serial_data_oe,
    output logic                          ee_data_sampled,
    output logic [`NUM_PORTS-1:0]         port_power_enable_n,
    output logic [`NUM_PORTS-1:0]         port_slow_slew,
    output logic [`NUM_PORTS-1:0]         port_overcurrent,
    output hub_power_pkg::straps_t        straps,
    output logic                          straps_valid,
    output logic                          pll_power_down,
    output logic                          pll_bypass,
    output logic                          osc_power_down,
    output logic                          core_clk_ext_select,
    output logic                          use_default_ids
);

    localparam int CW = $clog2(OC_CYCLES + 1);

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Two flops each; only the second stage is read by logic
    logic [`NUM_PORTS-1:0] oc_meta;
    logic [`NUM_PORTS-1:0] oc_sync;
    logic [3:0]            strap_meta;
    logic [3:0]            strap_sync;
    logic                  eed_meta;
    logic                  eed_sync;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oc_meta    <= `OC_IDLE_N;
            oc_sync    <= `OC_IDLE_N;
            strap_meta <= `STRAP_RESET;
            strap_sync <= `STRAP_RESET;
            eed_meta   <= 1'b0;
            eed_sync   <= 1'b0;
        end else begin
            oc_meta    <= port_overcurrent_n;
            oc_sync    <= oc_meta;
            strap_meta <= {bus_power_strap, clock_source_select, eeprom_disable_strap, eeprom_serial_data_in};
            strap_sync <= strap_meta;
            eed_meta   <= eeprom_serial_data_in;
            eed_sync   <= eed_meta;
        end
    end

    // ======================================================================
    // Strap capture
    // ======================================================================
    // Straps are static, so they are taken once after the synchronisers
    // have filled; later pin movement is ignored rather than glitching modes
    hub_power_pkg::cap_state_t state;
    hub_power_pkg::cap_state_t next_state;
    hub_power_pkg::straps_t    next_straps;
    logic [1:0]                cap_cnt;
    logic [1:0]                next_cap_cnt;

    always_comb begin
        next_state   = state;
        next_straps  = straps;
        next_cap_cnt = cap_cnt;
        case (state)
            hub_power_pkg::ST_SETTLE: begin
                if (cap_cnt == 2'(`STRAP_SYNC_CYCLES)) begin
                    next_straps.bus_powered = strap_sync[3];
                    next_straps.ext_clock   = strap_sync[2];
                    next_straps.eeprom_off  = strap_sync[1];
                    next_straps.ganged      = strap_sync[1] & strap_sync[0];
                    next_state              = hub_power_pkg::ST_RUN;
                end else begin
                    next_cap_cnt = cap_cnt + 2'h1;
                end
            end
            hub_power_pkg::ST_RUN: next_state = hub_power_pkg::ST_RUN;
            default:               next_state = hub_power_pkg::ST_SETTLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state   <= hub_power_pkg::ST_SETTLE;
            straps  <= `STRAP_RESET;
            cap_cnt <= 2'h0;
        end else begin
            state   <= next_state;
            straps  <= next_straps;
            cap_cnt <= next_cap_cnt;
        end
    end

    assign straps_valid = (state == hub_power_pkg::ST_RUN);

    // ======================================================================
    // Clock source and EEPROM pin sharing
    // ======================================================================
    // The PLL turns the 6 MHz reference into the 48 MHz core clock that also
    // keeps the 12 MHz bit clock aligned; with the external clock it idles
    logic next_pll_pd;
    logic next_ee_clk_out;
    logic next_ee_clk_oe;
    logic next_ee_dat_out;
    logic next_ee_dat_oe;
    logic next_ee_sampled;

    always_comb begin
        next_pll_pd     = straps.ext_clock;
        next_ee_clk_oe  = straps_valid & ~straps.eeprom_off & ee_active;
        next_ee_dat_oe  = next_ee_clk_oe & ee_data_oe_req;
        next_ee_clk_out = next_ee_clk_oe & ee_clock_drive;
        next_ee_dat_out = next_ee_dat_oe & ee_data_drive;
        next_ee_sampled = ~straps.eeprom_off & eed_sync;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pll_power_down          <= 1'b0;
            eeprom_serial_clock_out <= 1'b0;
            eeprom_serial_clock_oe  <= 1'b0;
            eeprom_serial_data_out  <= 1'b0;
            eeprom_serial_data_oe   <= 1'b0;
            ee_data_sampled         <= 1'b0;
        end else begin
            pll_power_down          <= next_pll_pd;
            eeprom_serial_clock_out <= next_ee_clk_out;
            eeprom_serial_clock_oe  <= next_ee_clk_oe;
            eeprom_serial_data_out  <= next_ee_dat_out;
            eeprom_serial_data_oe   <= next_ee_dat_oe;
            ee_data_sampled         <= next_ee_sampled;
        end
    end

    // Bypass, oscillator and clock mux all follow the same strap
    assign pll_bypass          = pll_power_down;
    assign osc_power_down      = pll_power_down;
    assign core_clk_ext_select = pll_power_down;
    assign use_default_ids     = straps.eeprom_off;

    // ======================================================================
    // Per-port overcurrent filter and power switching
    // ======================================================================
    // A fault is held until the host drops the port's power request (port 0's
    // request when ganged), so a shorted load cannot oscillate the switch on and off
    logic [`NUM_PORTS-1:0] any_fault;
    assign any_fault = {`NUM_PORTS{|port_overcurrent}};

    genvar i;
    generate
        for (i = 0; i < `NUM_PORTS; i++) begin : g_port
            logic [CW-1:0] cnt;
            logic [CW-1:0] next_cnt;
            logic          next_filt;
            logic          trip;
            logic          next_trip;
            logic          next_en_n;
            logic          next_slow;
            logic          fault;
            logic          req;

            always_comb begin
                next_cnt  = cnt;
                next_filt = port_overcurrent[i];
                if (oc_sync[i]) begin
                    next_cnt  = '0;
                    next_filt = 1'b0;
                end else if (cnt == CW'(OC_CYCLES - 1)) begin
                    next_filt = 1'b1;
                end else begin
                    next_cnt = cnt + CW'(1);
                end
                fault     = straps.ganged ? any_fault[i] : port_overcurrent[i];
                req       = straps.ganged ? port_power_request[0] : port_power_request[i];
                next_trip = fault | (req & trip);                             // Set wins over a dropped request
                next_en_n = ~(straps_valid & req & ~trip & ~fault);
                next_slow = port_low_speed[i];
            end

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt                    <= '0;
                    port_overcurrent[i]    <= 1'b0;
                    trip                   <= 1'b0;
                    port_power_enable_n[i] <= 1'b1;
                    port_slow_slew[i]      <= 1'b0;
                end else begin
                    cnt                    <= next_cnt;
                    port_overcurrent[i]    <= next_filt;
                    trip                   <= next_trip;
                    port_power_enable_n[i] <= next_en_n;
                    port_slow_slew[i]      <= next_slow;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_gang_same_state: assert property (straps.ganged && $past(straps.ganged) |->
        (port_power_enable_n == `PORTS_OFF_N) || (port_power_enable_n == 4'h0))
        else $error("ganged enables differ");
    a_gang_fault_off: assert property (straps.ganged && (port_overcurrent != 4'h0)
        |=> port_power_enable_n == `PORTS_OFF_N)
        else $error("ganged fault left a port powered");
    a_port_own_fault: assert property (!straps.ganged && port_overcurrent[2]
        && !port_overcurrent[0] && !g_port[0].trip && straps_valid && port_power_request[0]
        |=> !port_power_enable_n[0] && port_power_enable_n[2])
        else $error("per-port fault leaked to another port");
    a_filter_count: assert property ($rose(port_overcurrent[0]) |->
        !$past(oc_sync[0]) && $past(g_port[0].cnt) == CW'(OC_CYCLES - 1))
        else $error("overcurrent flagged before full count");
    a_spike_ignored: assert property (!port_overcurrent[0] && !oc_sync[0]
        ##1 oc_sync[0] |=> !port_overcurrent[0])
        else $error("short spike taken as overcurrent");
    a_ext_clock_off: assert property (straps_valid && straps.ext_clock ##1 straps_valid
        |-> pll_power_down && osc_power_down && core_clk_ext_select)
        else $error("PLL left running on external clock");
    a_pll_selected: assert property (straps_valid && !straps.ext_clock
        |=> !core_clk_ext_select && !pll_power_down)
        else $error("PLL not selected");
    a_eeprom_released: assert property (!ee_active || straps.eeprom_off
        |=> !eeprom_serial_clock_oe && !eeprom_serial_data_oe)
        else $error("EEPROM pins driven while idle");
    a_reset_ports_off: assert property (!straps_valid
        |-> port_power_enable_n == `PORTS_OFF_N)
        else $error("port powered before straps settled");
    a_slew_follow: assert property (port_low_speed[2] |=> port_slow_slew[2])
        else $error("slew not following speed");
    a_bus_strap_held: assert property (straps_valid |=> $stable(straps))
        else $error("straps changed while running");

endmodule : hub_port_power_strap_control

// ### verif/port_switch_model.sv
// ==========================================================================
// Downstream power switch and overcurrent monitor model
// ==========================================================================
// Holds chosen overcurrent pins low for a commanded number of cycles.
// Assumes the bench pulses fault_go for one clk cycle per fault.
`timescale 1ns/1ps

module port_switch_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ganged,
    input  wire logic [3:0] fault_mask,
    input  wire logic [7:0] fault_len,
    input  wire logic       fault_go,
    output logic      [3:0] port_overcurrent_n
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [3:0] mask_q;
    logic [3:0] next_mask_q;

    // ==========================================================================
    // Fault timer
    // ==========================================================================
    // Timer reloads on each command so a spike length is exact
    always_comb begin
        next_cnt    = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
        next_mask_q = mask_q;
        if (fault_go) begin
            next_cnt    = fault_len;
            next_mask_q = fault_mask;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt    <= 8'h00;
            mask_q <= 4'h0;
        end else begin
            cnt    <= next_cnt;
            mask_q <= next_mask_q;
        end
    end

    // Fault pulls low, idle level is high; ganged pins are tied together
    assign port_overcurrent_n = (cnt == 8'h00) ? 4'hF :
                                ganged ? {4{~|mask_q}} : ~mask_q;
endmodule : port_switch_model

// ### verif/testbench.sv
// ==========================================================================
// Port power and strap control bench
// ==========================================================================
// Per-port, ganged and EEPROM strap setups with filtered faults.
// Assumes the model above stands on the overcurrent pins.
`timescale 1ns/1ps
`include "hub_power_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module testbench;
    localparam int OC = 4;
    logic clk = 1'b0, nrst = 1'b0, bps = 1'b0, css = 1'b0, off = 1'b1, gpin = 1'b0;
    logic [3:0] req = 4'h0, lsp = 4'h0, fmask = 4'h0, oc_n, pen_n, slew, oc, prev, oc_seen, exp_v;
    logic [7:0] flen = 8'h00;
    logic go = 1'b0, ee_act = 1'b0, ee_ck = 1'b0, ee_dt = 1'b0, ee_oe = 1'b0;
    logic ck_o, ck_oe, dt_o, dt_oe, svalid, pll_pd, pll_by, osc_pd, ext_sel, def_ids, dsamp;
    hub_power_pkg::straps_t straps;
    logic [3:0] exp_q[$];
    int miscompares = 0, checked = 0;
    int unsigned r;

    always #4 clk = ~clk;

    hub_port_power_strap_control #(.OC_CYCLES(OC)) dut (
        .clk(clk), .nrst(nrst), .bus_power_strap(bps), .clock_source_select(css),
        .eeprom_disable_strap(off), .port_overcurrent_n(oc_n), .port_power_request(req),
        .port_low_speed(lsp), .ee_active(ee_act), .ee_clock_drive(ee_ck), .ee_data_drive(ee_dt),
        .ee_data_oe_req(ee_oe), .eeprom_serial_data_in(gpin), .eeprom_serial_clock_out(ck_o),
        .eeprom_serial_clock_oe(ck_oe), .eeprom_serial_data_out(dt_o), .eeprom_serial_data_oe(dt_oe),
        .ee_data_sampled(dsamp), .port_power_enable_n(pen_n), .port_slow_slew(slew),
        .port_overcurrent(oc), .straps(straps), .straps_valid(svalid), .pll_power_down(pll_pd),
        .pll_bypass(pll_by), .osc_power_down(osc_pd), .core_clk_ext_select(ext_sel),
        .use_default_ids(def_ids));

    port_switch_model partner (
        .clk(clk), .nrst(nrst), .ganged(gpin & off), .fault_mask(fmask), .fault_len(flen),
        .fault_go(go), .port_overcurrent_n(oc_n));

    // ==========================================================================
    // Tasks
    // ==========================================================================
    task automatic wrap_up;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // Straps are set before release and held, as the capture needs
    task automatic do_reset(input logic eoff, input logic gang);
        int i;
        @(posedge clk);
        nrst <= 1'b0; req <= 4'h0; ee_act <= 1'b0; ee_oe <= 1'b0;
        off <= eoff; gpin <= gang; r = $urandom; bps <= r[0]; css <= r[1];
        @(posedge clk);
        #1 `CHK(pen_n, `PORTS_OFF_N)
        `CHK(svalid, 1'b0)
        @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 20 && svalid !== 1'b1; i++) @(posedge clk);
        if (svalid !== 1'b1) begin miscompares++; wrap_up(); end
        #1 `CHK(straps, hub_power_pkg::straps_t'({bps, css, off, gpin & off}))
        `CHK({pll_pd, pll_by, osc_pd, ext_sel}, {4{css}})
        `CHK(def_ids, off)
    endtask : do_reset

    task automatic fault(input logic [3:0] m, input logic [7:0] n);
        @(posedge clk);
        fmask <= m; flen <= n; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : fault

    // Waits for every noted enable change, then idles to catch extra ones
    task automatic drain;
        int i;
        for (i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge clk);
        if (exp_q.size() != 0) begin miscompares++; wrap_up(); end
        repeat (10) @(posedge clk);
    endtask : drain

    // ==========================================================================
    // Enable monitor
    // ==========================================================================
    // A change with no note pending is compared against the old level;
    // the note is popped once so a mismatch print cannot eat a second one
    always @(posedge clk) begin
        if (!nrst) prev <= pen_n;
        else if (pen_n !== prev) begin
            prev <= pen_n;
            exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : prev;
            `CHK(pen_n, exp_v)
        end
    end

    // Sticky record of filtered faults, cleared by each reset
    always @(posedge clk) oc_seen <= nrst ? (oc_seen | oc) : 4'h0;

    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        r = $urandom(56);
        do_reset(1'b1, 1'b0);
        exp_q.push_back(4'h0);
        @(posedge clk) req <= 4'hF;
        drain();
        exp_q.push_back(4'h4);
        fault(4'h4, 8'(OC + 4));
        drain();
        fault(4'h1, 8'(OC - 1));
        drain();
        `CHK(pen_n, 4'h4)
        `CHK(oc_seen, 4'h4)
        r = $urandom;
        @(posedge clk) lsp <= r[3:0];
        repeat (3) @(posedge clk);
        `CHK(slew, r[3:0])
        @(posedge clk) begin ee_act <= 1'b1; ee_oe <= 1'b1; end
        repeat (3) @(posedge clk);
        `CHK({ck_oe, dt_oe}, 2'b00)
        $display("test per_port done");

        do_reset(1'b1, 1'b1);
        exp_q.push_back(4'h0);
        r = $urandom;
        @(posedge clk) req <= {r[2:0], 1'b1};
        drain();
        exp_q.push_back(4'hF);
        fault(4'h8, 8'(OC + 4));
        drain();
        `CHK(oc_seen, 4'hF)
        $display("test ganged done");

        do_reset(1'b0, 1'b0);
        r = $urandom;
        @(posedge clk) begin ee_act <= 1'b1; ee_oe <= 1'b1; ee_ck <= r[0]; ee_dt <= r[1]; gpin <= r[2]; end
        repeat (3) @(posedge clk);
        #1 `CHK({ck_oe, dt_oe, ck_o, dt_o}, {2'b11, r[0], r[1]})
        `CHK(dsamp, r[2])
        @(posedge clk) ee_act <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({ck_oe, dt_oe}, 2'b00)
        $display("test eeprom done");
        wrap_up();
    end
endmodule : testbench
